// ### logic/ipm_sync.sv
module ipm_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } ipm_sync_state_type;

   ipm_sync_state_type sync_r;
   ipm_sync_state_type sync_nxt;

   // First stage feeds only the second stage
   always_comb begin
      sync_nxt.stage1 = asyncIn;
      sync_nxt.stage2 = sync_r.stage1;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         sync_r <= '0;
      end else begin
         sync_r <= sync_nxt;
      end
   end

   assign syncOut = sync_r.stage2;
endmodule : ipm_sync

// ### logic/ipm_top.sv
package ipm_pkg;
   localparam int DATA_W   = 8;
   localparam int ADDR_W   = 4;
   localparam int NUM_CHAN = 5;
   localparam int NUM_EXT  = 6;

   typedef logic [ADDR_W-1:0] ipm_addr_type;
   typedef logic [DATA_W-1:0] ipm_byte_type;

   // Register offsets on the plain register port
   localparam ipm_addr_type ADDR_PSW_CTL   = 4'h0;
   localparam ipm_addr_type ADDR_MASK_A    = 4'h1;
   localparam ipm_addr_type ADDR_MASK_B    = 4'h2;
   localparam ipm_addr_type ADDR_PEND_A    = 4'h3;
   localparam ipm_addr_type ADDR_PEND_B    = 4'h4;
   localparam ipm_addr_type ADDR_IRQ_STAT  = 4'h5;
   localparam ipm_addr_type ADDR_IRQ_MASK  = 4'h6;

   localparam ipm_byte_type RESET_BYTE     = 8'h00;

   // Program-status control byte
   localparam int PSW_IO_MASK_BIT  = 6;
   localparam int PSW_EXT_MASK_BIT = 7;

   // Source mask A
   localparam int SOURCE_MASK_A_TIMER_BIT   = 0;
   localparam int SOURCE_MASK_A_INT_BIT     = 1;
   localparam int SOURCE_MASK_A_EXTSIG_BIT  = 2;
   localparam ipm_byte_type SOURCE_MASK_A_USED = 8'h07;

   // Channel mask B: bit 0 multiplex, bits 1..4 selector channels
   localparam ipm_byte_type CHANNEL_MASK_B_USED = 8'h1f;

   // Source pending A
   localparam int PA_TIMER_BIT     = 2;
   localparam int PA_EXTSIG_BIT    = 3;
   localparam int PA_SYSCTL_BIT    = 4;
   localparam int PA_CPUSIG0_BIT   = 5;
   localparam int PA_CPUSIG1_BIT   = 6;
   localparam int PA_STOP_BIT      = 7;

   // Channel pending B: bits 0..4 follow the channels
   localparam int PB_IO_BIT        = 5;
   localparam int PB_TUPD_BIT      = 6;
   localparam int PB_EXT_BIT       = 7;

   // Width of the bundle of asynchronous source inputs
   localparam int SRC_W = NUM_CHAN + NUM_EXT + 7;
endpackage : ipm_pkg

// Contract
// - Pending bit only while source active and permitted
// - Pending A: timer, extsig, sysctl, cpusig0/1, stop
// - Condition: external interrupt latch is on, PSW ext mask is on and a timer or extsig source is permitted
// - Timer needs mask A bit 0; externals bit 2
// - Mask A: timer, interrupt, extsig; rest reserved
// - Mask B: multiplex, selector 1-4; rest reserved
module ipm_top
   import ipm_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rstn,
   input  wire ipm_pkg::ipm_addr_type  regAddr,
   input  wire ipm_pkg::ipm_byte_type  regWdata,
   input  wire logic                   regWr,
   input  wire logic                   regRd,
   output ipm_pkg::ipm_byte_type       regRdata,
   input  wire logic [ipm_pkg::NUM_CHAN-1:0] chanReq,
   input  wire logic                   timerReq,
   input  wire logic                   timerUpdReq,
   input  wire logic [ipm_pkg::NUM_EXT-1:0]  extSigReq,
   input  wire logic                   sysCtlReq,
   input  wire logic                   cpuSig0Req,
   input  wire logic                   cpuSig1Req,
   input  wire logic                   procStopReq,
   input  wire logic                   scpuSignal,
   output ipm_pkg::ipm_byte_type       sourcePendingA,
   output ipm_pkg::ipm_byte_type       channelPendingB,
   output logic                        irq
);
   import ipm_pkg::*;

   typedef struct packed {
      ipm_byte_type pswCtl;
      ipm_byte_type source_mask_a;
      ipm_byte_type channel_mask_b;
      ipm_byte_type pendA;
      ipm_byte_type pendB;
      logic         extLatch;
      ipm_byte_type irqStat;
      ipm_byte_type irqMask;
      ipm_byte_type rdata;
      logic         irq;
   } ipm_state_type;

   localparam ipm_state_type STATE_RESET = '{
      pswCtl:   RESET_BYTE,
      source_mask_a:     RESET_BYTE,
      channel_mask_b:     RESET_BYTE,
      pendA:    RESET_BYTE,
      pendB:    RESET_BYTE,
      extLatch: 1'h0,
      irqStat:  RESET_BYTE,
      irqMask:  RESET_BYTE,
      rdata:    RESET_BYTE,
      irq:      1'h0
   };

   ipm_state_type st_r;
   ipm_state_type st_nxt;

   logic [SRC_W-1:0] srcAsync;
   logic [SRC_W-1:0] srcSync;

   // Sources come from other logic blocks with no common timing
   assign srcAsync = {scpuSignal, procStopReq, cpuSig1Req, cpuSig0Req, sysCtlReq,
                      extSigReq, timerUpdReq, timerReq, chanReq};

   ipm_sync #(
      .WIDTH   (SRC_W)
   ) srcSyncInst (
      .clk     (clk),
      .rstn    (rstn),
      .asyncIn (srcAsync),
      .syncOut (srcSync)
   );

   logic [NUM_CHAN-1:0] chanS;
   logic                timerS;
   logic                timerUpdS;
   logic [NUM_EXT-1:0]  extSigS;
   logic                sysCtlS;
   logic                cpuSig0S;
   logic                cpuSig1S;
   logic                procStopS;
   logic                scpuS;

   assign chanS     = srcSync[NUM_CHAN-1:0];
   assign timerS    = srcSync[NUM_CHAN];
   assign timerUpdS = srcSync[NUM_CHAN+1];
   assign extSigS   = srcSync[NUM_CHAN+2 +: NUM_EXT];
   assign sysCtlS   = srcSync[NUM_CHAN+NUM_EXT+2];
   assign cpuSig0S  = srcSync[NUM_CHAN+NUM_EXT+3];
   assign cpuSig1S  = srcSync[NUM_CHAN+NUM_EXT+4];
   assign procStopS = srcSync[NUM_CHAN+NUM_EXT+5];
   assign scpuS     = srcSync[NUM_CHAN+NUM_EXT+6];

   // Address match gated by the write strobe, used only by write decoding; reads decode with a case
   function automatic logic isWrite(input ipm_addr_type a, input logic wr,
                                    input ipm_addr_type target);
      isWrite = wr && (a == target);
   endfunction : isWrite

   always_comb begin
      ipm_byte_type pA;
      ipm_byte_type pB;
      ipm_byte_type rise;
      ipm_byte_type clr;
      logic         extCond;
      logic         extSrcOk;
      logic         ioOn;
      logic         extOn;

      pA       = RESET_BYTE;
      pB       = RESET_BYTE;
      rise     = RESET_BYTE;
      clr      = RESET_BYTE;
      extCond  = 1'h0;
      extSrcOk = 1'h0;
      ioOn     = 1'h0;
      extOn    = 1'h0;
      st_nxt   = st_r;

      // Register writes; reserved mask bits never store
      if (isWrite(regAddr, regWr, ADDR_PSW_CTL)) begin
         st_nxt.pswCtl = regWdata;
      end
      if (isWrite(regAddr, regWr, ADDR_MASK_A)) begin
         st_nxt.source_mask_a = regWdata & SOURCE_MASK_A_USED;
      end
      if (isWrite(regAddr, regWr, ADDR_MASK_B)) begin
         st_nxt.channel_mask_b = regWdata & CHANNEL_MASK_B_USED;
      end
      if (isWrite(regAddr, regWr, ADDR_IRQ_MASK)) begin
         st_nxt.irqMask = regWdata;
      end
      if (isWrite(regAddr, regWr, ADDR_IRQ_STAT)) begin
         clr = regWdata;
      end

      // Latch follows the signalling CPU register
      st_nxt.extLatch = scpuS;

      ioOn  = st_r.pswCtl[PSW_IO_MASK_BIT];
      extOn = st_r.pswCtl[PSW_EXT_MASK_BIT];

      // Pending bits are levels: they drop as soon as source or mask drops
      pA[PA_TIMER_BIT]   = timerS && st_r.source_mask_a[SOURCE_MASK_A_TIMER_BIT];
      pA[PA_EXTSIG_BIT]  = (|extSigS) && st_r.source_mask_a[SOURCE_MASK_A_EXTSIG_BIT] && extOn;
      pA[PA_SYSCTL_BIT]  = sysCtlS && st_r.source_mask_a[SOURCE_MASK_A_INT_BIT];
      pA[PA_CPUSIG0_BIT] = cpuSig0S && st_r.source_mask_a[SOURCE_MASK_A_INT_BIT];
      pA[PA_CPUSIG1_BIT] = cpuSig1S && st_r.source_mask_a[SOURCE_MASK_A_INT_BIT];
      // Process stop is not maskable
      pA[PA_STOP_BIT]    = procStopS;

      for (int i = 0; i < NUM_CHAN; i++) begin
         pB[i] = chanS[i] && st_r.channel_mask_b[i] && ioOn;
      end
      pB[PB_IO_BIT]   = |pB[NUM_CHAN-1:0];
      pB[PB_TUPD_BIT] = timerUpdS;

      extSrcOk = (timerS && st_r.source_mask_a[SOURCE_MASK_A_TIMER_BIT])
               || ((|extSigS) && st_r.source_mask_a[SOURCE_MASK_A_EXTSIG_BIT]);
      extCond  = st_r.extLatch && extOn && extSrcOk;
      pB[PB_EXT_BIT] = extCond;

      st_nxt.pendA = pA;
      st_nxt.pendB = pB;

      // New pending-B assertions are events; set beats a same-cycle clear
      rise = pB & ~st_r.pendB;
      st_nxt.irqStat = (st_r.irqStat & ~clr) | rise;
      st_nxt.irq     = |(st_nxt.irqStat & st_nxt.irqMask);

      // Read data stand for exactly the cycle after the strobe
      st_nxt.rdata = RESET_BYTE;
      if (regRd) begin
         case (regAddr)
            ADDR_PSW_CTL:  st_nxt.rdata = st_r.pswCtl;
            ADDR_MASK_A:   st_nxt.rdata = st_r.source_mask_a;
            ADDR_MASK_B:   st_nxt.rdata = st_r.channel_mask_b;
            ADDR_PEND_A:   st_nxt.rdata = st_r.pendA;
            ADDR_PEND_B:   st_nxt.rdata = st_r.pendB;
            ADDR_IRQ_STAT: st_nxt.rdata = st_r.irqStat;
            ADDR_IRQ_MASK: st_nxt.rdata = st_r.irqMask;
            default:       st_nxt.rdata = RESET_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_r <= STATE_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign regRdata        = st_r.rdata;
   assign sourcePendingA  = st_r.pendA;
   assign channelPendingB = st_r.pendB;
   assign irq             = st_r.irq;
endmodule : ipm_top

// ### sim/ipm_src_model.sv
module ipm_src_model
   import ipm_pkg::*;
(
   input  wire logic                         clk,
   input  wire logic [ipm_pkg::SRC_W-1:0]    want,
   output logic      [ipm_pkg::NUM_CHAN-1:0] chanReq,
   output logic                              timerReq,
   output logic                              timerUpdReq,
   output logic      [ipm_pkg::NUM_EXT-1:0]  extSigReq,
   output logic                              sysCtlReq,
   output logic                              cpuSig0Req,
   output logic                              cpuSig1Req,
   output logic                              procStopReq,
   output logic                              scpuSignal
);
   timeunit 1ns;
   timeprecision 1ps;
   // Sources change only after an edge, as real request logic would
   always_ff @(posedge clk) begin
      {chanReq, timerReq, timerUpdReq, extSigReq, sysCtlReq, cpuSig0Req, cpuSig1Req,
       procStopReq, scpuSignal} <= want;
   end
endmodule : ipm_src_model

// ### sim/ipm_top_chk.sv
module ipm_top_chk
   import ipm_pkg::*;
(
   input wire logic                         clk,
   input wire logic                         rstn,
   input wire ipm_pkg::ipm_addr_type        regAddr,
   input wire logic                         regRd,
   input wire ipm_pkg::ipm_byte_type        regRdata,
   input wire logic [ipm_pkg::NUM_CHAN-1:0] chanReq,
   input wire logic                         timerReq,
   input wire logic                         timerUpdReq,
   input wire logic                         procStopReq,
   input wire ipm_pkg::ipm_byte_type        sourcePendingA,
   input wire ipm_pkg::ipm_byte_type        channelPendingB
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] upCnt_r;
   // Latency checks look three edges back, so wait until that history is clean
   always_ff @(posedge clk) begin
      if (!rstn) upCnt_r <= 3'h0;
      else if (upCnt_r != 3'h7) upCnt_r <= upCnt_r + 3'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   a_spare_zero: assert property (sourcePendingA[1:0] == 2'h0)
      else $error("spare pending bits set");
   a_stop_follow: assert property (upCnt_r > 3'h3 |->
      sourcePendingA[PA_STOP_BIT] == $past(procStopReq, 3)) else $error("stop pending wrong");
   a_tupd_follow: assert property (upCnt_r > 3'h3 |->
      channelPendingB[PB_TUPD_BIT] == $past(timerUpdReq, 3)) else $error("timer update wrong");
   a_io_summary: assert property (channelPendingB[PB_IO_BIT] == |channelPendingB[4:0])
      else $error("io summary wrong");
   a_chan_source: assert property (upCnt_r > 3'h3 |->
      (channelPendingB[4:0] & ~$past(chanReq, 3)) == '0) else $error("channel without source");
   a_timer_source: assert property (upCnt_r > 3'h3 && sourcePendingA[PA_TIMER_BIT]
      |-> $past(timerReq, 3)) else $error("timer without source");
   a_rsvd_maska: assert property ($past(regRd) && $past(regAddr) == ADDR_MASK_A
      |-> regRdata[7:3] == 5'h0) else $error("mask a reserved bits set");
   a_rsvd_maskb: assert property ($past(regRd) && $past(regAddr) == ADDR_MASK_B
      |-> regRdata[7:5] == 3'h0) else $error("mask b reserved bits set");
endmodule : ipm_top_chk
bind ipm_top ipm_top_chk chk_u (.*);

// ### sim/tb_top.sv
module tb_top;
   import ipm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0, irq;
   ipm_addr_type regAddr = '0;
   ipm_byte_type regWdata = '0, regRdata, sourcePendingA, channelPendingB;
   logic [NUM_CHAN-1:0] chanReq;
   logic [NUM_EXT-1:0] extSigReq;
   logic timerReq, timerUpdReq, sysCtlReq, cpuSig0Req, cpuSig1Req, procStopReq, scpuSignal;
   logic [SRC_W-1:0] want = '0;
   int errCount = 0, nCompared = 0, cycles = 0;
   // Source order: chan, timer, tupd, ext, sysctl, cpu0, cpu1, stop, signalling_cpu_register
   logic [SRC_W-1:0] wTab [12] = '{18'h3ffff, 18'h01000, 18'h01001, 18'h00401, 18'h00010,
      18'h00008, 18'h00004, 18'h00002, 18'h00001, 18'h02000, 18'h20000, 18'h00800};
   logic [15:0] eTab [12] = '{16'hfcff, 16'h0400, 16'h0480, 16'h0880, 16'h1000, 16'h2000,
      16'h4000, 16'h8000, 16'h0000, 16'h0021, 16'h0030, 16'h0040};
   always #5 clk = ~clk;
   ipm_src_model src_u (.*);
   ipm_top dut_u (.*);
   task automatic chk(input ipm_byte_type got, input ipm_byte_type exp);
      nCompared++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
         errCount++;
      end
   endtask : chk
   task automatic wr(input ipm_addr_type a, input ipm_byte_type d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input ipm_addr_type a, input ipm_byte_type exp);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk(regRdata, exp);
   endtask : rd
   // Six edges cover model delay, synchroniser and the latch stage
   task automatic src(input logic [SRC_W-1:0] w, input ipm_byte_type ea, input ipm_byte_type eb);
      @(posedge clk);
      want <= w;
      repeat (6) @(posedge clk);
      #1 chk(sourcePendingA, ea);
      chk(channelPendingB, eb);
   endtask : src
   task stop_test;
      $display("compared %0d mismatches %0d", nCompared, errCount);
      if (errCount == 0 && nCompared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         errCount++;
         stop_test();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00);
      wr(ADDR_MASK_A, 8'hff);
      rd(ADDR_MASK_A, 8'h07);
      wr(ADDR_MASK_B, 8'hff);
      rd(ADDR_MASK_B, 8'h1f);
      wr(ADDR_PSW_CTL, 8'hc0);
      rd(ADDR_PSW_CTL, 8'hc0);
      wr(ADDR_PEND_A, 8'hff);
      wr(4'hf, 8'hff);
      rd(ADDR_PEND_A, 8'h00);
      for (int i = 0; i < 12; i++) src(wTab[i], eTab[i][15:8], eTab[i][7:0]);
      wr(ADDR_PSW_CTL, 8'h40);
      src(18'h01401, 8'h04, 8'h00);
      wr(ADDR_PSW_CTL, 8'h80);
      src(18'h3e000, 8'h00, 8'h00);
      wr(ADDR_PSW_CTL, 8'hc0);
      wr(ADDR_MASK_A, 8'h02);
      src(18'h0141f, 8'hf0, 8'h00);
      wr(ADDR_MASK_A, 8'h04);
      src(18'h0141f, 8'h88, 8'h80);
      wr(ADDR_MASK_A, 8'h01);
      src(18'h0141f, 8'h84, 8'h80);
      wr(ADDR_MASK_B, 8'h00);
      src(18'h3e800, 8'h00, 8'h40);
      // Every pending B bit has risen once, none are enabled yet
      rd(ADDR_IRQ_STAT, 8'hff);
      chk({7'h0, irq}, 8'h00);
      wr(ADDR_IRQ_MASK, 8'h40);
      repeat (2) @(posedge clk);
      #1 chk({7'h0, irq}, 8'h01);
      wr(ADDR_IRQ_STAT, 8'hff);
      repeat (2) @(posedge clk);
      #1 chk({7'h0, irq}, 8'h00);
      rd(ADDR_IRQ_STAT, 8'h00);
      rd(ADDR_IRQ_MASK, 8'h40);
      stop_test();
   end
endmodule : tb_top
